// File: src/address_block_counters.sv
// top: locator and block counters with APB registers and interrupt
// Notes on behaviour
// - each counter can be enabled or stopped every cycle, internally or externally.
// - locator counter increments each clock while enabled; 16 or 22 bits wide.
// - locator counter enable comes from a control register bit.
// - io line one can drive locator enable when its special function is on.
// - all-ones flag sets when counter is all ones; cleared by load or by a switch to narrow mode while any of bits 21:16 is set.
// - locator counter keeps counting and wraps past all ones while enabled.
// - all-ones flag is a condition code and can raise interrupt zero.
// - narrow mode drives counter onto address bus only while select bit set.
// - wide mode with select bit set: upper 16 bits drive address bus, lower 6 go to host lines.
// - a configuration register bit chooses narrow or wide counting.
// - select bit clear puts output register on bus; counter counts events.
// - block counter is 16-bit down counter enabled by a control bit.
// - block counter decrements each clock while enabled.
// - io line zero can drive block enable when its special function is on.
// - block counter keeps decrementing past zero while enabled.
// - block zero flag latches at zero; cleared only by loading counter.
// - software reads counters while counting and may load new values.
//
// Register access over APB and the placing of the registers were chosen for this implementation.
module address_block_counters (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [loc_counters_pkg::ADDR_W-1:0] paddr,
	input wire logic [loc_counters_pkg::DATA_W-1:0] pwdata,
	output logic [loc_counters_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// external enables on io lines one and zero
	input wire logic ioLineOne,
	input wire logic ioLineZero,
	// address bus and host locator lines
	output logic [loc_counters_pkg::LOC_W_NARROW-1:0] addrBus,
	output logic [loc_counters_pkg::LOC_LOWER_W-1:0] hostLocatorLines,
	output logic hostLocatorLinesOe,
	// condition codes and interrupt
	output logic counterAllOnesFlag,
	output logic blockCountZeroFlag,
	output logic irq
);
	import loc_counters_pkg::*;

	logic [DATA_W-1:0] ctrlReg;
	logic [DATA_W-1:0] cfgReg;
	logic [LOC_W_NARROW-1:0] locatorOutputRegister;
	logic [IRQ_W-1:0] irqStatus;
	logic [IRQ_W-1:0] irqEnable;
	logic [LOC_W_MAX-1:0] locCount;
	logic [BLOCK_W-1:0] blockCount;
	logic locFlag;
	logic blockFlag;
	logic locEvent;
	logic blockEvent;

	// apb decode: zero-wait access, answered in the access cycle
	wire access = psel & penable;
	wire wr = access & pwrite;
	wire hitCtrl = paddr == OFF_CTRL;
	wire hitCfg = paddr == OFF_CONFIG;
	wire hitLoc = paddr == OFF_LOC_COUNT;
	wire hitBlock = paddr == OFF_BLOCK_COUNT;
	wire hitOut = paddr == OFF_OUT_REG;
	wire hitFlags = paddr == OFF_FLAGS;
	wire hitStatus = paddr == OFF_IRQ_STATUS;
	wire hitEnable = paddr == OFF_IRQ_ENABLE;
	wire hitClear = paddr == OFF_IRQ_CLEAR;
	wire mapped = hitCtrl | hitCfg | hitLoc | hitBlock | hitOut | hitFlags | hitStatus
		| hitEnable | hitClear;

	// mode and enable selection
	wire wideCountModeBit = cfgReg[CFG_WIDE];
	wire locatorSourceSelectBit = ctrlReg[CTRL_SEL];
	wire locatorCountEnableBit = cfgReg[CFG_IO1_SPECIAL] ? ioLineOne
		: ctrlReg[CTRL_LOC_EN];
	wire blockCountEnableBit = cfgReg[CFG_IO0_SPECIAL] ? ioLineZero
		: ctrlReg[CTRL_BLOCK_EN];

	// narrow mode counts 16 bits and wraps there; upper bits are held at zero
	wire [LOC_W_MAX-1:0] narrowMask = {{(LOC_W_MAX-LOC_W_NARROW){1'b0}},
		{LOC_W_NARROW{1'b1}}};
	wire [LOC_W_MAX-1:0] locMask = wideCountModeBit ? {LOC_W_MAX{1'b1}} : narrowMask;
	wire locLoad = wr & hitLoc;
	wire [LOC_W_MAX-1:0] locLoadValue = pwdata[LOC_W_MAX-1:0] & locMask;
	wire [LOC_W_MAX-1:0] locNarrowed = locCount & locMask;
	wire blockLoad = wr & hitBlock;

	up_down_counter #(
		.WIDTH(LOC_W_MAX),
		.DOWN(1'b0)
	) locatorCounter (
		.clk(clk),
		.srst(srst),
		.load(locLoad | (~wideCountModeBit & (locCount != locNarrowed))),
		.loadValue(locLoad ? locLoadValue : locNarrowed),
		.enable(locatorCountEnableBit & (locCount == locNarrowed)),
		.termMask(locMask),
		.count(locCount),
		.termFlag(locFlag),
		.termEvent(locEvent)
	);

	up_down_counter #(
		.WIDTH(BLOCK_W),
		.DOWN(1'b1)
	) blockDownCounter (
		.clk(clk),
		.srst(srst),
		.load(blockLoad),
		.loadValue(pwdata[BLOCK_W-1:0]),
		.enable(blockCountEnableBit),
		.termMask({BLOCK_W{1'b1}}),
		.count(blockCount),
		.termFlag(blockFlag),
		.termEvent(blockEvent)
	);

	// address routing
	wire [LOC_W_NARROW-1:0] locatorCountUpper = wideCountModeBit
		? locCount[LOC_W_MAX-1:LOC_LOWER_W] : locCount[LOC_W_NARROW-1:0];
	wire [LOC_LOWER_W-1:0] locatorCountLower = locCount[LOC_LOWER_W-1:0];
	wire [LOC_W_NARROW-1:0] next_addrBus = locatorSourceSelectBit ? locatorCountUpper
		: locatorOutputRegister;
	// host lines only carry the low bits in wide mode with the counter selected
	wire next_hostOe = wideCountModeBit & locatorSourceSelectBit;

	// interrupt: set wins over clear
	wire [IRQ_W-1:0] events = {blockEvent, locEvent};
	wire [IRQ_W-1:0] clearMask = (wr & hitClear) ? pwdata[IRQ_W-1:0] : '0;
	wire [IRQ_W-1:0] next_irqStatus = (irqStatus & ~clearMask) | events;
	wire [IRQ_W-1:0] next_irqEnable = (wr & hitEnable) ? pwdata[IRQ_W-1:0] : irqEnable;

	// read mux, live values so counting continues during reads
	wire [DATA_W-1:0] flagsWord = {{(DATA_W-2){1'b0}}, blockFlag, locFlag};
	wire [DATA_W-1:0] readWord =
		hitCtrl ? ctrlReg :
		hitCfg ? cfgReg :
		hitLoc ? {{(DATA_W-LOC_W_MAX){1'b0}}, locCount} :
		hitBlock ? {{(DATA_W-BLOCK_W){1'b0}}, blockCount} :
		hitOut ? {{(DATA_W-LOC_W_NARROW){1'b0}}, locatorOutputRegister} :
		hitFlags ? flagsWord :
		hitStatus ? {{(DATA_W-IRQ_W){1'b0}}, irqStatus} :
		hitEnable ? {{(DATA_W-IRQ_W){1'b0}}, irqEnable} :
		RESET_WORD;
	// read word is captured in the setup cycle so it stands together with pready
	wire setupPhase = psel & ~penable;
	wire [DATA_W-1:0] next_prdata = (setupPhase & ~pwrite & mapped) ? readWord : SLVERR_WORD;

	wire [DATA_W-1:0] ctrlMask = (DATA_W'(1) << CTRL_LOC_EN) | (DATA_W'(1) << CTRL_BLOCK_EN)
		| (DATA_W'(1) << CTRL_SEL);
	wire [DATA_W-1:0] cfgMask = (DATA_W'(1) << CFG_WIDE) | (DATA_W'(1) << CFG_IO1_SPECIAL)
		| (DATA_W'(1) << CFG_IO0_SPECIAL);

	// pready toggles so each access phase gets exactly one answer
	wire next_pready = psel & ~penable;

	always_ff @(posedge clk) begin
		if (srst) begin
			ctrlReg <= RESET_WORD;
			cfgReg <= RESET_WORD;
			locatorOutputRegister <= '0;
			irqStatus <= '0;
			irqEnable <= '0;
		end else begin
			if (wr & hitCtrl & pready) ctrlReg <= pwdata & ctrlMask;
			if (wr & hitCfg & pready) cfgReg <= pwdata & cfgMask;
			if (wr & hitOut & pready) locatorOutputRegister <= pwdata[LOC_W_NARROW-1:0];
			irqStatus <= next_irqStatus;
			irqEnable <= next_irqEnable;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			addrBus <= '0;
			hostLocatorLines <= '0;
			hostLocatorLinesOe <= 1'b0;
			counterAllOnesFlag <= 1'b0;
			blockCountZeroFlag <= 1'b0;
			irq <= 1'b0;
		end else begin
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pready & ~mapped;
			addrBus <= next_addrBus;
			hostLocatorLines <= next_hostOe ? locatorCountLower : '0;
			hostLocatorLinesOe <= next_hostOe;
			counterAllOnesFlag <= locFlag;
			blockCountZeroFlag <= blockFlag;
			irq <= |(next_irqStatus & next_irqEnable);
		end
	end
endmodule : address_block_counters

// File: src/loc_counters_pkg.sv
// package: register map, field layout and reset values of the counter pair
package loc_counters_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 12;
	localparam int LOC_W_MAX = 22;
	localparam int LOC_W_NARROW = 16;
	localparam int LOC_LOWER_W = 6;
	localparam int BLOCK_W = 16;
	localparam int IRQ_W = 2;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_CONFIG = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_LOC_COUNT = 12'h008;
	localparam logic [ADDR_W-1:0] OFF_BLOCK_COUNT = 12'h00c;
	localparam logic [ADDR_W-1:0] OFF_OUT_REG = 12'h010;
	localparam logic [ADDR_W-1:0] OFF_FLAGS = 12'h014;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 12'h018;
	localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 12'h01c;
	localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR = 12'h020;

	// control register fields
	localparam int CTRL_LOC_EN = 0;
	localparam int CTRL_BLOCK_EN = 1;
	localparam int CTRL_SEL = 9;
	// configuration register fields
	localparam int CFG_WIDE = 0;
	localparam int CFG_IO1_SPECIAL = 1;
	localparam int CFG_IO0_SPECIAL = 2;
	// flag and interrupt bit positions
	localparam int FLAG_ALL_ONES = 0;
	localparam int FLAG_BLOCK_ZERO = 1;

	localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;
	localparam logic [DATA_W-1:0] SLVERR_WORD = 32'h0000_0000;
endpackage : loc_counters_pkg

// File: src/up_down_counter.sv
// counter cell: load, step up or down, latched terminal flag
module up_down_counter #(
	parameter int WIDTH = 16,
	parameter bit DOWN = 1'b0
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// control
	input wire logic load,
	input wire logic [WIDTH-1:0] loadValue,
	input wire logic enable,
	input wire logic [WIDTH-1:0] termMask,
	// state
	output logic [WIDTH-1:0] count,
	output logic termFlag,
	output logic termEvent
);
	import loc_counters_pkg::*;

	// step wraps inside the active width so a narrow count loses no cycle at wrap
	wire [WIDTH-1:0] stepped = (DOWN ? count - 1'b1 : count + 1'b1) & termMask;
	wire [WIDTH-1:0] next_count = load ? loadValue : (enable ? stepped : count);
	// terminal value: all ones within the active width, or zero for down count
	wire next_term = DOWN ? ((next_count & termMask) == '0)
		: ((next_count & termMask) == termMask);
	wire changed = load | enable;
	wire hit = changed & next_term & ~load;

	always_ff @(posedge clk) begin
		if (srst) begin
			count <= '0;
			termFlag <= 1'b0;
			termEvent <= 1'b0;
		end else begin
			count <= next_count;
			// flag stays until a load; a load clears it
			termFlag <= load ? 1'b0 : (termFlag | hit);
			termEvent <= hit;
		end
	end
endmodule : up_down_counter

// File: tb/abc_monitor.sv
// checker: apb handshake, host line and flag timing of the counter pair
module abc_monitor (
	input wire logic clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [loc_counters_pkg::ADDR_W-1:0] paddr,
	input wire logic [loc_counters_pkg::DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [loc_counters_pkg::LOC_LOWER_W-1:0] hostLocatorLines,
	input wire logic hostLocatorLinesOe,
	input wire logic counterAllOnesFlag,
	input wire logic blockCountZeroFlag
);
	timeunit 1ns;
	timeprecision 1ns;
	import loc_counters_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	sequence s_load(logic [ADDR_W-1:0] a);
		psel && penable && pwrite && paddr == a;
	endsequence
	a_ready_setup: assert property (psel && !penable |=> pready) else $error("late ready");
	a_ready_single: assert property (pready |=> !pready) else $error("ready held");
	a_err_empty: assert property (pslverr |-> pready && prdata == '0) else $error("bad err");
	a_lines_quiet: assert property (!hostLocatorLinesOe |-> hostLocatorLines == '0)
		else $error("lines driven");
	a_ones_load: assert property (s_load(OFF_LOC_COUNT) |=> ##1 !counterAllOnesFlag)
		else $error("ones not cleared");
	a_zero_load: assert property (s_load(OFF_BLOCK_COUNT) |=> ##1 !blockCountZeroFlag)
		else $error("zero not cleared");
	a_ones_hold: assert property ($fell(counterAllOnesFlag) |-> $past(srst) || $past(srst, 2)
		|| $past(psel && penable && pwrite && paddr == OFF_LOC_COUNT, 2)) else $error("ones lost");
	a_zero_hold: assert property ($fell(blockCountZeroFlag) |-> $past(srst) || $past(srst, 2)
		|| $past(psel && penable && pwrite && paddr == OFF_BLOCK_COUNT, 2)) else $error("zero lost");
endmodule : abc_monitor

bind address_block_counters abc_monitor u_abc_monitor (.clk(clk), .srst(srst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .hostLocatorLines(hostLocatorLines), .hostLocatorLinesOe(hostLocatorLinesOe),
	.counterAllOnesFlag(counterAllOnesFlag), .blockCountZeroFlag(blockCountZeroFlag));

// File: tb/host_line_model.sv
// partner: host side of the shared low locator lines
module host_line_model (
	input wire logic clk,
	input wire logic [loc_counters_pkg::LOC_LOWER_W-1:0] devLines,
	input wire logic devOe,
	output logic [loc_counters_pkg::LOC_LOWER_W-1:0] wireLevel
);
	timeunit 1ns;
	timeprecision 1ns;
	import loc_counters_pkg::*;
	logic [LOC_LOWER_W-1:0] hostAddr = 6'h15;
	always @(posedge clk) hostAddr <= ~hostAddr;
	// host floats its own address while the counter drives the lines
	assign wireLevel = devOe ? devLines : hostAddr;
endmodule : host_line_model

// File: tb/test_address_block_counters.sv
// bench: counter pair through apb registers and io lines
module test_address_block_counters;
	timeunit 1ns;
	timeprecision 1ns;
	import loc_counters_pkg::*;
	logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, io1 = 0, io0 = 0, err;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0, prdata, rd, a;
	logic pready, pslverr, oe, ones, zero, irq;
	logic [LOC_W_NARROW-1:0] bus;
	logic [LOC_LOWER_W-1:0] lines, wl;
	int failures = 0, n_checks = 0;
	always #5 clk = ~clk;
	address_block_counters u_address_block_counters (.clk(clk), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ioLineOne(io1), .ioLineZero(io0), .addrBus(bus),
		.hostLocatorLines(lines), .hostLocatorLinesOe(oe), .counterAllOnesFlag(ones),
		.blockCountZeroFlag(zero), .irq(irq));
	host_line_model u_host_line_model (.clk(clk), .devLines(lines), .devOe(oe), .wireLevel(wl));
	task automatic chk(input logic [DATA_W-1:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		// pready is read as it stands at each rising edge; prdata and pslverr only at the edge that finds it high
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		if (pready !== 1'b1) failures++;
		psel <= 0;
		penable <= 0;
	endtask : xfer
	task automatic t_block();
		xfer(1, OFF_CONFIG, 32'h4);
		xfer(1, OFF_BLOCK_COUNT, 32'h2);
		io0 <= 1;
		repeat (3) @(posedge clk);
		io0 <= 0;
		repeat (3) @(posedge clk);
		chk(zero, 1);
		xfer(0, OFF_BLOCK_COUNT, 0);
		chk(rd, 32'h0000_ffff);
		xfer(0, OFF_FLAGS, 0);
		chk(rd[FLAG_BLOCK_ZERO], 1);
		xfer(1, OFF_CONFIG, 32'h0);
		xfer(1, OFF_BLOCK_COUNT, 32'h100);
		xfer(1, OFF_CTRL, 32'h2);
		xfer(0, OFF_BLOCK_COUNT, 0);
		a = rd;
		xfer(0, OFF_BLOCK_COUNT, 0);
		chk(rd < a, 1);
		chk(zero, 0);
		xfer(1, OFF_CTRL, 32'h0);
	endtask : t_block
	task automatic t_loc();
		xfer(1, OFF_CONFIG, 32'h3);
		xfer(1, OFF_CTRL, 32'h200);
		xfer(1, OFF_LOC_COUNT, 32'h3f_fffe);
		io1 <= 1;
		@(posedge clk);
		io1 <= 0;
		repeat (3) @(posedge clk);
		chk(ones, 1);
		chk(bus, 16'hffff);
		chk(wl, 6'h3f);
		io1 <= 1;
		@(posedge clk);
		io1 <= 0;
		repeat (3) @(posedge clk);
		chk(ones, 1);
		xfer(0, OFF_LOC_COUNT, 0);
		chk(rd, 32'h0);
		xfer(1, OFF_IRQ_ENABLE, 32'h1);
		repeat (3) @(posedge clk);
		chk(irq, 1);
		xfer(1, OFF_IRQ_ENABLE, 32'h0);
		repeat (3) @(posedge clk);
		chk(irq, 0);
		xfer(1, OFF_IRQ_ENABLE, 32'h1);
		xfer(1, OFF_IRQ_CLEAR, 32'h1);
		repeat (3) @(posedge clk);
		chk(irq, 0);
		xfer(0, OFF_IRQ_STATUS, 0);
		chk(rd, 32'h2);
	endtask : t_loc
	task automatic t_narrow();
		xfer(1, OFF_CONFIG, 32'h0);
		xfer(1, OFF_LOC_COUNT, 32'h1234);
		io1 <= 1;
		repeat (3) @(posedge clk);
		io1 <= 0;
		repeat (3) @(posedge clk);
		chk(ones, 0);
		chk(bus, 16'h1234);
		chk(oe, 0);
		xfer(1, OFF_LOC_COUNT, 32'hfffe);
		xfer(1, OFF_CTRL, 32'h201);
		xfer(1, OFF_CTRL, 32'h200);
		repeat (3) @(posedge clk);
		chk(ones, 1);
		xfer(0, OFF_LOC_COUNT, 0);
		chk(rd, 32'h1);
		xfer(1, OFF_OUT_REG, 32'hbeef);
		xfer(1, OFF_CTRL, 32'h0);
		repeat (3) @(posedge clk);
		chk(bus, 16'hbeef);
		xfer(0, 12'h100, 0);
		chk(err, 1);
		chk(rd, 32'h0);
	endtask : t_narrow
	task automatic final_report();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : final_report
	initial begin
		#100000;
		failures++;
		final_report();
	end
	initial begin
		repeat (20) @(posedge clk);
		srst <= 0;
		t_block();
		t_loc();
		t_narrow();
		final_report();
	end
endmodule : test_address_block_counters
